// [msl_top.sv]
/*
 Mode select and status indicators of a USB to field-bus master converter.
 Assumes one 100 MHz clock, a synchronous reboot reset, and that the USB
 and field UART engines live outside and hand bytes over on this clock.
*/
`timescale 1ns/1ps
`include "msl_cfg.svh"

module msl_top #(
   parameter int HALF_CYC = `MSL_FLASH_HALF_CYC,
   parameter int BIT_CYC  = `MSL_BIT_CYCLES
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Board jumper pin
   input  wire logic                  mode_select_jumper,
   // Host side byte stream
   input  wire msl_pkg::msl_byte_type usb_rx,
   input  wire logic                  usb_rx_done,
   output msl_pkg::msl_byte_type      usb_tx,
   // Field side byte stream
   input  wire msl_pkg::msl_byte_type field_rx,
   input  wire logic                  field_rx_done,
   output msl_pkg::msl_byte_type      field_tx,
   // Mode and rate to the engines
   output logic                       mass_storage_en,
   output logic                       bridge_en,
   output logic [16:0]                link_bit_cycles,
   // Indicators
   output msl_pkg::msl_ind_type       ind
);
   // Jumper pin crosses into the clock domain
   logic sync1_ff;
   logic sync2_ff;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= mode_select_jumper;
         sync2_ff <= sync1_ff;
      end
   end

   // Mode: wait for synchroniser to fill, then latch once
   msl_pkg::msl_mode_type mode_ff;
   msl_pkg::msl_mode_type nxt_mode;
   logic [1:0]            boot_cnt_ff;
   logic [1:0]            nxt_boot_cnt;

   always_comb begin
      nxt_mode     = mode_ff;
      nxt_boot_cnt = boot_cnt_ff;
      case (mode_ff)
         msl_pkg::MSL_BOOT: begin
            if (boot_cnt_ff == 2'h2) begin
               if (sync2_ff == `MSL_JUMPER_UPDATE) begin
                  nxt_mode = msl_pkg::MSL_UPDATE;
               end else begin
                  nxt_mode = msl_pkg::MSL_OPERATE;
               end
            end else begin
               nxt_boot_cnt = boot_cnt_ff + 2'h1;
            end
         end
         msl_pkg::MSL_UPDATE:  nxt_mode = msl_pkg::MSL_UPDATE;
         msl_pkg::MSL_OPERATE: nxt_mode = msl_pkg::MSL_OPERATE;
         default:              nxt_mode = msl_pkg::MSL_BOOT;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_ff     <= msl_pkg::MSL_BOOT;
         boot_cnt_ff <= 2'h0;
      end else begin
         mode_ff     <= nxt_mode;
         boot_cnt_ff <= nxt_boot_cnt;
      end
   end

   wire logic operate = (mode_ff == msl_pkg::MSL_OPERATE);

   // Transfer-busy tracking; a new byte beats a done in the same cycle
   logic usb_busy_ff;
   logic field_busy_ff;
   logic nxt_usb_busy;
   logic nxt_field_busy;

   // One direction per call; busy never survives leaving operation mode
   function automatic logic busy_next(
      input logic busy,
      input logic valid,
      input logic done,
      input logic run
   );
      logic nxt_busy;
      nxt_busy = busy;
      if (!run) begin
         nxt_busy = 1'b0;
      end else if (valid) begin
         nxt_busy = 1'b1;
      end else if (done) begin
         nxt_busy = 1'b0;
      end
      return nxt_busy;
   endfunction

   always_comb begin
      nxt_usb_busy   = busy_next(usb_busy_ff, usb_rx.valid, usb_rx_done, operate);
      nxt_field_busy = busy_next(field_busy_ff, field_rx.valid, field_rx_done, operate);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         usb_busy_ff   <= 1'b0;
         field_busy_ff <= 1'b0;
      end else begin
         usb_busy_ff   <= nxt_usb_busy;
         field_busy_ff <= nxt_field_busy;
      end
   end

   // Byte bridge, one cycle of latency each way
   msl_pkg::msl_byte_type usb_tx_ff;
   msl_pkg::msl_byte_type field_tx_ff;
   msl_pkg::msl_byte_type nxt_usb_tx;
   msl_pkg::msl_byte_type nxt_field_tx;

   always_comb begin
      nxt_field_tx = '0;
      nxt_usb_tx   = '0;
      if (operate) begin
         nxt_field_tx = usb_rx;
         nxt_usb_tx   = field_rx;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         usb_tx_ff   <= '0;
         field_tx_ff <= '0;
      end else begin
         usb_tx_ff   <= nxt_usb_tx;
         field_tx_ff <= nxt_field_tx;
      end
   end

   // Mode and rate outputs; the rate needs 17 bits, 16 would wrap it
   // Rate is constant but still leaves a flop like every other output
   logic                  ms_en_ff;
   logic                  br_en_ff;
   logic                  pwr_ff;
   logic [16:0]           rate_ff;
   logic                  nxt_ms_en;
   logic                  nxt_br_en;
   logic                  nxt_pwr;
   logic [16:0]           nxt_rate;

   always_comb begin
      nxt_ms_en = (mode_ff == msl_pkg::MSL_UPDATE);
      nxt_br_en = operate;
      nxt_pwr   = operate;
      nxt_rate  = 17'(BIT_CYC);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ms_en_ff <= 1'b0;
         br_en_ff <= 1'b0;
         pwr_ff   <= 1'b0;
         rate_ff  <= 17'(BIT_CYC);
      end else begin
         ms_en_ff <= nxt_ms_en;
         br_en_ff <= nxt_br_en;
         pwr_ff   <= nxt_pwr;
         rate_ff  <= nxt_rate;
      end
   end

   // Flashers gated by mode so update mode stays dark
   logic usb_lamp;
   logic field_lamp;

   msl_flasher #(
      .HALF_CYC (HALF_CYC)
   ) u_usb_flash (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (operate),
      .active (usb_busy_ff),
      .lamp   (usb_lamp)
   );

   msl_flasher #(
      .HALF_CYC (HALF_CYC)
   ) u_field_flash (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (operate),
      .active (field_busy_ff),
      .lamp   (field_lamp)
   );

   assign usb_tx          = usb_tx_ff;
   assign field_tx        = field_tx_ff;
   assign mass_storage_en = ms_en_ff;
   assign bridge_en       = br_en_ff;
   assign link_bit_cycles = rate_ff;
   // One driver for the whole indicator struct
   assign ind             = '{power: pwr_ff, usb_act: usb_lamp, field_act: field_lamp};
endmodule

// [msl_cfg.svh]
/*
 Timing counts and constants for the mode select and indicator block.
 Assumes a 100 MHz system clock and inclusion by bare name.
*/
`ifndef MSL_CFG_SVH
`define MSL_CFG_SVH

`define MSL_CLK_HZ          100000000
`define MSL_LINK_BPS        1200
`define MSL_BIT_CYCLES      (`MSL_CLK_HZ / `MSL_LINK_BPS)
`define MSL_FLASH_HALF_MS   50
`define MSL_FLASH_HALF_CYC  ((`MSL_CLK_HZ / 1000) * `MSL_FLASH_HALF_MS)
`define MSL_JUMPER_UPDATE   1'b1

`endif

// [msl_pkg.sv]
/*
 Types for the mode select and indicator block.
 Assumes msl_cfg.svh is compiled alongside.
*/
package msl_pkg;
   typedef enum logic [1:0] {
      MSL_BOOT,
      MSL_UPDATE,
      MSL_OPERATE
   } msl_mode_type;

   typedef struct packed {
      logic power;
      logic usb_act;
      logic field_act;
   } msl_ind_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } msl_byte_type;
endpackage

// [msl_flasher.sv]
/*
 One activity indicator: toggles at a fixed half period while busy,
 returns dark once the transfer ends.
 Assumes active and enable come from the same clock domain.
*/
`timescale 1ns/1ps
`include "msl_cfg.svh"

module msl_flasher #(
   parameter int HALF_CYC = `MSL_FLASH_HALF_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic enable,
   input  wire logic active,
   // Indicator
   output logic      lamp
);
   localparam int CW = $clog2(HALF_CYC + 1);

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic          lamp_ff;
   logic          nxt_lamp;

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_lamp = lamp_ff;
      if (!enable || !active) begin
         nxt_cnt  = '0;
         nxt_lamp = 1'b0;
      end else if (cnt_ff == CW'(HALF_CYC - 1)) begin
         nxt_cnt  = '0;
         nxt_lamp = ~lamp_ff;
      end else begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff  <= '0;
         lamp_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         lamp_ff <= nxt_lamp;
      end
   end

   assign lamp = lamp_ff;
endmodule

// [msl_chk.sv]
/* Assertions on the ports of msl_top.
   Assumes bind below and a flash half period of at most 4. */
`timescale 1ns/1ps
module msl_chk #(
   parameter int HALF_CYC = 4,
   parameter int BIT_CYC  = 83333
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Pins and streams
   input wire logic                  mode_select_jumper,
   input wire msl_pkg::msl_byte_type usb_rx,
   input wire logic                  usb_rx_done,
   input wire msl_pkg::msl_byte_type usb_tx,
   input wire msl_pkg::msl_byte_type field_rx,
   input wire logic                  field_rx_done,
   input wire msl_pkg::msl_byte_type field_tx,
   // Mode and indicators
   input wire logic                  mass_storage_en,
   input wire logic                  bridge_en,
   input wire logic [16:0]           link_bit_cycles,
   input wire msl_pkg::msl_ind_type  ind
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence usb_go;
      bridge_en && usb_rx.valid && !usb_rx_done;
   endsequence
   // Window of 8 only spans a toggle while HALF_CYC stays small
   sequence usb_quiet;
      (!usb_rx_done && !usb_rx.valid) [*8];
   endsequence
   sequence usb_stop;
      usb_rx_done && !usb_rx.valid ##1 !usb_rx.valid;
   endsequence
   chk_mode_set: assert property ($rose(rst_n) |-> ##6 (bridge_en ^ mass_storage_en))
      else $error("mode not set");
   chk_mode_frozen: assert property (bridge_en |=> bridge_en)
      else $error("mode changed");
   chk_update_dark: assert property (mass_storage_en |-> ind == '0)
      else $error("lamp lit in update");
   chk_power_on: assert property (bridge_en |-> ind.power)
      else $error("power lamp off");
   chk_usb_fwd: assert property (bridge_en && usb_rx.valid |=> field_tx == $past(usb_rx))
      else $error("host byte lost");
   chk_field_fwd: assert property (bridge_en && field_rx.valid |=> usb_tx == $past(field_rx))
      else $error("field byte lost");
   chk_no_fwd: assert property (mass_storage_en |-> !field_tx.valid && !usb_tx.valid)
      else $error("bytes in update");
   chk_usb_flash: assert property (usb_go ##1 usb_quiet |-> ind.usb_act != $past(ind.usb_act, HALF_CYC))
      else $error("lamp not toggling");
   chk_usb_dark: assert property (usb_stop |=> !ind.usb_act)
      else $error("lamp lit after done");
   chk_bit_rate: assert property (link_bit_cycles == BIT_CYC)
      else $error("bit period wrong");
endmodule
bind msl_top msl_chk #(.HALF_CYC(HALF_CYC), .BIT_CYC(BIT_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
   .mode_select_jumper(mode_select_jumper), .usb_rx(usb_rx), .usb_rx_done(usb_rx_done),
   .usb_tx(usb_tx), .field_rx(field_rx), .field_rx_done(field_rx_done), .field_tx(field_tx),
   .mass_storage_en(mass_storage_en), .bridge_en(bridge_en),
   .link_bit_cycles(link_bit_cycles), .ind(ind));

// [msl_partner.sv]
/* Far-side engine handing one frame of bytes to the block.
   Assumes go is seen high at exactly one falling edge. */
`timescale 1ns/1ps
module msl_partner (
   // Control
   input  wire logic             clk,
   input  wire logic             go,
   input  wire logic [7:0]       first,
   input  wire logic [7:0]       len,
   input  wire logic [7:0]       gap,
   // Stream
   output msl_pkg::msl_byte_type rx,
   output logic                  done
);
   initial rx = '0;
   initial done = 1'b0;
   always begin
      @(negedge clk);
      if (go) begin
         for (int i = 0; i < len; i++) begin
            rx <= {1'b1, first + 8'(i)};
            @(negedge clk);
            if (gap != 0 || i == len - 1) begin
               // Stale data inverted, never left looking settled
               rx <= {1'b0, ~rx.data};
               repeat (gap) @(negedge clk);
            end
         end
         done <= 1'b1;
         @(negedge clk);
         done <= 1'b0;
      end
   end
endmodule

// [test_mode_select_led_status.sv]
/* Testbench of msl_top with queue model of forwarding and lamps.
   Assumes msl_partner and msl_chk compiled first. */
`timescale 1ns/1ps
`include "msl_cfg.svh"
module test_mode_select_led_status;
   logic                  clk = 1'b0, rst_n = 1'b0, jmp = 1'b0;
   logic                  u_go = 1'b0, f_go = 1'b0, exp_op = 1'b0, chk_on = 1'b0;
   logic                  u_done, f_done, seen_u, seen_f;
   logic [7:0]            u_first = 8'h00, f_first = 8'h00, len = 8'h01, gap = 8'h00;
   logic [15:0]           lfsr = 16'h8651;
   int                    error_cnt = 0, total_checks = 0;
   msl_pkg::msl_byte_type u_rx, f_rx, u_tx, f_tx;
   msl_pkg::msl_ind_type  ind;
   logic                  ms_en, br_en;
   logic [16:0]           lbc;
   logic [7:0]            qf[$], qu[$];
   always #5 clk = ~clk;
   msl_partner pu (.clk(clk), .go(u_go), .first(u_first), .len(len), .gap(gap), .rx(u_rx),
      .done(u_done));
   msl_partner pf (.clk(clk), .go(f_go), .first(f_first), .len(len), .gap(gap), .rx(f_rx),
      .done(f_done));
   msl_top #(.HALF_CYC(4)) dut (.clk(clk), .rst_n(rst_n), .mode_select_jumper(jmp),
      .usb_rx(u_rx), .usb_rx_done(u_done), .usb_tx(u_tx), .field_rx(f_rx),
      .field_rx_done(f_done), .field_tx(f_tx), .mass_storage_en(ms_en), .bridge_en(br_en),
      .link_bit_cycles(lbc), .ind(ind));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      if (exp_op && u_rx.valid) qf.push_back(u_rx.data);
      if (exp_op && f_rx.valid) qu.push_back(f_rx.data);
   end
   always @(negedge clk) if (rst_n) begin
      if (f_tx.valid !== 1'b0) check(f_tx.data, qf.size() ? qf.pop_front() : 8'hXX);
      if (u_tx.valid !== 1'b0) check(u_tx.data, qu.size() ? qu.pop_front() : 8'hXX);
      if (chk_on) check(ind.power, exp_op);
      seen_u |= ind.usb_act;
      seen_f |= ind.field_act;
   end
   task automatic boot(input logic j);
      chk_on = 1'b0;
      exp_op = 1'b0;
      @(negedge clk);
      rst_n = 1'b0;
      jmp = j;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      exp_op = !j;
      chk_on = 1'b1;
      check({ms_en, br_en}, {j, !j});
      check(lbc, `MSL_BIT_CYCLES);
      jmp = !j;
      repeat (10) @(negedge clk);
      check({ms_en, br_en, ind}, {j, !j, !j, 2'b00});
      $display("boot done, jumper %0b", j);
   endtask
   task automatic frame(input logic u, input logic f);
      logic du, df;
      lfsr = nxt(lfsr);
      len = {5'h0, lfsr[2:0]} + 8'h8;
      gap = {4'h0, lfsr[6:3]};
      u_first = lfsr[15:8];
      f_first = ~lfsr[15:8];
      seen_u = 1'b0;
      seen_f = 1'b0;
      du = !u;
      df = !f;
      @(negedge clk);
      // Non-blocking so the partners see go at exactly one falling edge
      u_go <= u;
      f_go <= f;
      @(negedge clk);
      u_go <= 1'b0;
      f_go <= 1'b0;
      for (int i = 0; i < 3000 && !(du && df); i++) begin
         @(posedge clk);
         du |= u_done;
         df |= f_done;
      end
      if (!(du && df)) begin
         error_cnt++;
         give_verdict();
      end
      repeat (3) @(negedge clk);
      check(ind, {exp_op, 2'b00});
      check(seen_u, exp_op & u);
      check(seen_f, exp_op & f);
      check(16'(qf.size() + qu.size()), 16'h0);
      $display("frame done, usb %0b field %0b", u, f);
   endtask
   initial begin
      boot(1'b0);
      frame(1'b1, 1'b0);
      frame(1'b0, 1'b1);
      frame(1'b1, 1'b1);
      repeat (4) frame(lfsr[5], !lfsr[5]);
      boot(1'b1);
      frame(1'b1, 1'b1);
      boot(1'b0);
      frame(1'b1, 1'b1);
      give_verdict();
   end
endmodule
